// [core/scd_decoder.sv]
// Command decoder and executor front end for an ATA task-file storage card.
// Assumes command writes arrive as one-cycle strobes on the card clock, with the
// media, self-test and sector buffer engines outside reporting done pulses.
// What this block does
// - Both 98h and E5h decode as the same power-mode query.
// - Query while asleep or entering/leaving sleep: busy, count 00h, clear busy, interrupt.
// - Query while idle: busy, count FFh, clear busy, interrupt.
// - Code 90h starts the internal self tests.
// - Card modes: diagnostic runs only on the card selected by drive bit.
// - Native disk mode: drive bit ignored, master reports for both units.
// - Diagnostic result 01h to 05h goes into the error register.
// - Master reports slave failure as 8 in upper nibble, slave code low.
// - C0h is pre-erase, no data phase, may end with write fault.
// - Pre-erase start address comes from drive/head, cylinders and sector number.
// - Pre-erase conditions sectors for later writes without erase.
// - Parameter-less commands use only the drive bit, ignoring the head field.
// - Code 38h is class 2 with a data-out phase.
// - Code CDh is class 3.
// - Class 1: busy rises within 400 ns of the command write.
// - Class 2: busy, buffer ready, data request within 700 us, busy drops.
// - Class 3: busy, data request within 20 ms, busy drops in the same cycle.
`timescale 1ns/10ps
module scd_decoder #(
  parameter int unsigned CLASS2_LIMIT = scd_pkg::CLASS2_CYC,
  parameter int unsigned CLASS3_LIMIT = scd_pkg::CLASS3_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire scd_pkg::scd_taskfile_t taskfile,
  input wire logic native_disk_mode,
  input wire logic card_drive_id,
  input wire scd_pkg::scd_pwr_t power_state,
  input wire logic diag_done,
  input wire logic [2:0] diag_code,
  input wire logic slave_present,
  input wire logic slave_diag_done,
  input wire logic [3:0] slave_diag_code,
  input wire logic erase_done,
  input wire logic erase_fault,
  input wire logic buffer_ready,
  input wire logic data_phase_done,
  input wire logic intr_ack,
  output logic [7:0] status_reg,
  output logic [7:0] error_reg,
  output logic [7:0] sector_count_out,
  output logic sector_count_load,
  output logic intr_req,
  output logic diag_start,
  output logic erase_start,
  output logic [27:0] erase_addr,
  output logic [7:0] erase_count,
  output logic buffer_setup,
  output logic write_no_erase,
  output logic multi_sector
);
  typedef enum logic [2:0] {ST_IDLE, ST_PWR, ST_DIAG, ST_SLAVE, ST_ERASE, ST_BUF, ST_DATA, ST_DONE} scd_state_t;
  scd_state_t state;
  logic busy_flag;
  logic data_request_flag;
  logic wfault;
  logic err_flag;
  logic [7:0] own_diag;
  logic [scd_pkg::CNT_W-1:0] wait_cnt;
  logic [scd_pkg::CNT_W-1:0] wait_lim;

  function automatic scd_pkg::scd_class_t scd_classify(input logic [7:0] code);
    if (code == scd_pkg::CMD_PWR_A || code == scd_pkg::CMD_PWR_B || code == scd_pkg::CMD_DIAG ||
        code == scd_pkg::CMD_ERASE) begin
      return scd_pkg::CLS_1;
    end else if (code == scd_pkg::CMD_WR_NOERASE) begin
      return scd_pkg::CLS_2;
    end else if (code == scd_pkg::CMD_WRM_NOERASE) begin
      return scd_pkg::CLS_3;
    end
    return scd_pkg::CLS_NONE;
  endfunction

  wire scd_pkg::scd_class_t cls = scd_classify(cmd_code);
  wire is_pwr = (cmd_code == scd_pkg::CMD_PWR_A) || (cmd_code == scd_pkg::CMD_PWR_B);
  wire is_diag = cmd_code == scd_pkg::CMD_DIAG;
  wire is_erase = cmd_code == scd_pkg::CMD_ERASE;
  // Only the drive bit selects the card, except 90h in native disk mode; head field unused here
  wire drive_match = taskfile.drive_head_reg[scd_pkg::DRIVE_SEL_BIT] == card_drive_id;
  wire diag_here = native_disk_mode | drive_match;
  wire selected = is_diag ? diag_here : drive_match;
  // Host only writes while busy is clear
  wire accept = cmd_wr & ~busy_flag & selected;
  wire asleep = power_state != scd_pkg::PWR_IDLE;
  wire [7:0] own_code = {5'h00, diag_code};
  wire timeout = wait_cnt >= wait_lim;
  wire master_reports = native_disk_mode & slave_present & ~card_drive_id;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      busy_flag <= 1'b0;
      data_request_flag <= 1'b0;
      wfault <= 1'b0;
      err_flag <= 1'b0;
      error_reg <= 8'h00;
      own_diag <= 8'h00;
      sector_count_out <= 8'h00;
      sector_count_load <= 1'b0;
      intr_req <= 1'b0;
      diag_start <= 1'b0;
      erase_start <= 1'b0;
      erase_addr <= 28'h0000000;
      erase_count <= 8'h00;
      buffer_setup <= 1'b0;
      write_no_erase <= 1'b0;
      multi_sector <= 1'b0;
      wait_cnt <= '0;
      wait_lim <= '0;
    end else begin
      sector_count_load <= 1'b0;
      diag_start <= 1'b0;
      erase_start <= 1'b0;
      buffer_setup <= 1'b0;
      if (intr_ack) begin
        intr_req <= 1'b0;
      end
      wait_cnt <= wait_cnt + 1'b1;
      case (state)
        ST_IDLE: begin
          if (accept) begin
            // Busy rises on the cycle after the write, well inside the limit
            busy_flag <= 1'b1;
            err_flag <= 1'b0;
            wfault <= 1'b0;
            error_reg <= 8'h00;
            wait_cnt <= '0;
            if (is_pwr) begin
              state <= ST_PWR;
            end else if (is_diag) begin
              diag_start <= 1'b1;
              state <= ST_DIAG;
            end else if (is_erase) begin
              erase_addr <= {taskfile.drive_head_reg[3:0], taskfile.cylinder_regs,
                            taskfile.sector_number_reg};
              erase_count <= taskfile.sector_count_reg;
              erase_start <= 1'b1;
              state <= ST_ERASE;
            end else if (cls == scd_pkg::CLS_2 || cls == scd_pkg::CLS_3) begin
              buffer_setup <= 1'b1;
              write_no_erase <= 1'b1;
              multi_sector <= cls == scd_pkg::CLS_3;
              wait_lim <= (cls == scd_pkg::CLS_2) ? CLASS2_LIMIT[scd_pkg::CNT_W-1:0]
                                                  : CLASS3_LIMIT[scd_pkg::CNT_W-1:0];
              state <= ST_BUF;
            end else begin
              error_reg <= scd_pkg::ERR_ABORT;
              err_flag <= 1'b1;
              state <= ST_DONE;
            end
          end
        end
        ST_PWR: begin
          sector_count_out <= asleep ? scd_pkg::COUNT_SLEEP : scd_pkg::COUNT_IDLE;
          sector_count_load <= 1'b1;
          state <= ST_DONE;
        end
        ST_DIAG: begin
          if (diag_done) begin
            own_diag <= own_code;
            if (master_reports) begin
              state <= ST_SLAVE;
            end else begin
              error_reg <= own_code;
              state <= ST_DONE;
            end
          end
        end
        ST_SLAVE: begin
          if (slave_diag_done) begin
            if (slave_diag_code != scd_pkg::DIAG_PASS[3:0]) begin
              error_reg <= {scd_pkg::DIAG_SLAVE_NIB, slave_diag_code};
            end else begin
              error_reg <= own_diag;
            end
            state <= ST_DONE;
          end
        end
        ST_ERASE: begin
          if (erase_done) begin
            wfault <= erase_fault;
            err_flag <= erase_fault;
            state <= ST_DONE;
          end
        end
        ST_BUF: begin
          // Data request raised when the buffer is ready or at the time limit
          if (buffer_ready || timeout) begin
            data_request_flag <= 1'b1;
            busy_flag <= 1'b0;
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (data_phase_done) begin
            data_request_flag <= 1'b0;
            write_no_erase <= 1'b0;
            multi_sector <= 1'b0;
            intr_req <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_DONE: begin
          busy_flag <= 1'b0;
          intr_req <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    status_reg = 8'h00;
    status_reg[scd_pkg::STAT_BUSY] = busy_flag;
    status_reg[scd_pkg::STAT_READY] = ~busy_flag;
    status_reg[scd_pkg::STAT_WFAULT] = wfault;
    status_reg[scd_pkg::STAT_SEEK] = ~busy_flag;
    status_reg[scd_pkg::STAT_DATA_REQ] = data_request_flag;
    status_reg[scd_pkg::STAT_ERR] = err_flag;
  end
endmodule // scd_decoder

// [core/scd_pkg.sv]
// Package for the storage card command decoder: codes, fields, states, timing.
// Assumes a 100 MHz card clock.
package scd_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam logic [7:0] CMD_PWR_A = 8'h98;
  localparam logic [7:0] CMD_PWR_B = 8'hE5;
  localparam logic [7:0] CMD_DIAG = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'hC0;
  localparam logic [7:0] CMD_WR_NOERASE = 8'h38;
  localparam logic [7:0] CMD_WRM_NOERASE = 8'hCD;
  localparam logic [7:0] COUNT_SLEEP = 8'h00;
  localparam logic [7:0] COUNT_IDLE = 8'hFF;
  localparam logic [7:0] DIAG_PASS = 8'h01;
  localparam logic [7:0] DIAG_FORMATTER = 8'h02;
  localparam logic [7:0] DIAG_BUFFER = 8'h03;
  localparam logic [7:0] DIAG_ECC = 8'h04;
  localparam logic [7:0] DIAG_CPU = 8'h05;
  localparam logic [3:0] DIAG_SLAVE_NIB = 4'h8;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam int unsigned DRIVE_SEL_BIT = 4;
  localparam int unsigned STAT_BUSY = 7;
  localparam int unsigned STAT_READY = 6;
  localparam int unsigned STAT_WFAULT = 5;
  localparam int unsigned STAT_SEEK = 4;
  localparam int unsigned STAT_DATA_REQ = 3;
  localparam int unsigned STAT_ERR = 0;
  localparam int unsigned BUSY_NS = 400;
  localparam int unsigned BUSY_CYC = (BUSY_NS * CLK_MHZ) / 1000;
  localparam int unsigned CLASS2_US = 700;
  localparam int unsigned CLASS2_CYC = CLASS2_US * CLK_MHZ;
  localparam int unsigned CLASS3_MS = 20;
  localparam int unsigned CLASS3_CYC = CLASS3_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 22;
  typedef struct packed {
    logic [7:0] feature_reg;
    logic [7:0] sector_count_reg;
    logic [7:0] sector_number_reg;
    logic [15:0] cylinder_regs;
    logic [7:0] drive_head_reg;
  } scd_taskfile_t;
  typedef enum logic [1:0] {CLS_NONE, CLS_1, CLS_2, CLS_3} scd_class_t;
  typedef enum logic [1:0] {PWR_IDLE, PWR_SLEEP, PWR_ENTER_SLEEP, PWR_WAKE} scd_pwr_t;
endpackage

// [bench/scd_decoder_assertions.sv]
// Checker for the command decoder ports: command take, answers and flags.
// Assumes the task file stays steady while a command runs.
`timescale 1ns/10ps
module scd_decoder_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire scd_pkg::scd_taskfile_t taskfile,
  input wire logic native_disk_mode,
  input wire logic card_drive_id,
  input wire scd_pkg::scd_pwr_t power_state,
  input wire logic [7:0] status_reg,
  input wire logic [7:0] error_reg,
  input wire logic [7:0] sector_count_out,
  input wire logic sector_count_load,
  input wire logic intr_req,
  input wire logic diag_start,
  input wire logic erase_start,
  input wire logic [27:0] erase_addr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic busy = status_reg[7];
  wire logic sel = taskfile.drive_head_reg[4] == card_drive_id;
  wire logic take = cmd_wr && !busy && sel;
  wire logic pwr = take && (cmd_code == 8'h98 || cmd_code == 8'hE5);
  wire logic diag = cmd_wr && !busy && cmd_code == 8'h90;
  wire logic idle = power_state == scd_pkg::PWR_IDLE;
  a_busy_rise: assert property (take |=> busy) else $error("busy late");
  a_pwr_idle: assert property (pwr && idle |-> ##2 sector_count_load && sector_count_out == 8'hFF)
    else $error("idle count wrong");
  a_pwr_sleep: assert property (pwr && !idle |-> ##2 sector_count_load && sector_count_out == 8'h00)
    else $error("sleep count wrong");
  a_pwr_finish: assert property (pwr |=> busy ##2 !busy && intr_req) else $error("query end wrong");
  a_diag_native: assert property (diag && native_disk_mode |=> diag_start && busy) else $error("no diag");
  a_diag_unsel: assert property (diag && !native_disk_mode && !sel |=> !busy && !diag_start)
    else $error("unselected diag ran");
  a_erase_addr: assert property (erase_start |-> erase_addr == {taskfile.drive_head_reg[3:0],
    taskfile.cylinder_regs, taskfile.sector_number_reg}) else $error("erase address wrong");
  a_request_not_busy: assert property ($rose(status_reg[3]) |-> !busy) else $error("busy with request");
  a_abort_code: assert property (take && cmd_code == 8'h01 |=> error_reg == 8'h04 && status_reg[0]
    ##1 intr_req) else $error("abort wrong");
  c_pwr: cover property (pwr);
  c_erase: cover property (erase_start);
  c_data_req: cover property ($rose(status_reg[3]));
endmodule // scd_decoder_assertions
bind scd_decoder scd_decoder_assertions scd_decoder_assertions_inst (.ref_clk, .rst, .cmd_wr, .cmd_code,
  .taskfile, .native_disk_mode, .card_drive_id, .power_state, .status_reg, .error_reg, .sector_count_out,
  .sector_count_load, .intr_req, .diag_start, .erase_start, .erase_addr);

// [bench/scd_engine_model.sv]
// Engine model: self test, erase and buffer engines answering start pulses.
// Assumes one start pulse at a time from the decoder.
`timescale 1ns/10ps
module scd_engine_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic diag_start,
  input wire logic erase_start,
  input wire logic buffer_setup,
  input wire logic data_req,
  output logic diag_done,
  output logic slave_diag_done,
  output logic erase_done,
  output logic buffer_ready,
  output logic data_phase_done
);
  logic [3:0] cnt;
  logic [1:0] kind;
  logic [1:0] slave_q;
  wire logic fire = cnt == 4'h1;
  assign diag_done = fire && kind == 2'h1;
  assign erase_done = fire && kind == 2'h2;
  assign buffer_ready = fire && kind == 2'h3;
  assign slave_diag_done = slave_q[1];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {cnt, kind, slave_q, data_phase_done} <= '0;
    end else begin
      slave_q <= {slave_q[0], diag_done};
      data_phase_done <= data_req && !data_phase_done;
      if (diag_start || erase_start || buffer_setup) begin
        cnt <= 4'h4;
        kind <= {~diag_start, ~erase_start};
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // scd_engine_model

// [bench/tb_scd_decoder.sv]
// Bench for the command decoder: power query, abort, diagnostic, erase, writes.
// Assumes the engine model answers every start pulse.
`timescale 1ns/10ps
module tb_scd_decoder;
  logic ref_clk = 0, rst = 1, cmd_wr = 0, native_disk_mode = 0, card_drive_id = 0, erase_fault = 0, intr_ack = 0;
  logic [7:0] cmd_code = 8'h00, status_reg, error_reg, sector_count_out, erase_count;
  logic [2:0] diag_code = 3'h1;
  logic [3:0] slave_diag_code = 4'h1;
  logic slave_present = 1;
  logic [27:0] erase_addr;
  scd_pkg::scd_taskfile_t taskfile = '0;
  scd_pkg::scd_pwr_t power_state = scd_pkg::PWR_IDLE;
  logic sector_count_load, intr_req, diag_start, erase_start, buffer_setup, write_no_erase, multi_sector;
  logic diag_done, slave_diag_done, erase_done, buffer_ready, data_phase_done;
  int n_mismatch = 0, tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  scd_decoder #(.CLASS2_LIMIT(20), .CLASS3_LIMIT(40)) scd_decoder_inst (.ref_clk, .rst, .cmd_wr, .cmd_code,
    .taskfile, .native_disk_mode, .card_drive_id, .power_state, .diag_done, .diag_code, .slave_present,
    .slave_diag_done, .slave_diag_code, .erase_done, .erase_fault, .buffer_ready, .data_phase_done, .intr_ack,
    .status_reg, .error_reg, .sector_count_out, .sector_count_load, .intr_req, .diag_start, .erase_start,
    .erase_addr, .erase_count, .buffer_setup, .write_no_erase, .multi_sector);
  scd_engine_model scd_engine_model_inst (.ref_clk, .rst, .diag_start, .erase_start, .buffer_setup,
    .data_req(status_reg[3]), .diag_done, .slave_diag_done, .erase_done, .buffer_ready, .data_phase_done);
  task automatic check(string what, logic [27:0] seen, logic [27:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic issue(logic [7:0] code);
    @(negedge ref_clk);
    cmd_wr = 1;
    cmd_code = code;
    @(negedge ref_clk);
    cmd_wr = 0;
  endtask
  task automatic wait_for(bit want_req);
    int i;
    for (i = 0; i < 200 && (want_req ? status_reg[3] : intr_req) !== 1'b1; i++) @(negedge ref_clk);
    if (i == 200) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic ack();
    check("busy", status_reg[7], 1'b0);
    intr_ack = 1;
    @(negedge ref_clk);
    intr_ack = 0;
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 0;
    for (int c = 0; c < 8; c++) begin
      power_state = scd_pkg::scd_pwr_t'(c % 4);
      issue(c > 3 ? scd_pkg::CMD_PWR_B : scd_pkg::CMD_PWR_A);
      wait_for(0);
      check("count", sector_count_out, c % 4 == 0 ? 8'hFF : 8'h00);
      ack();
    end
    issue(8'h01);
    wait_for(0);
    check("abort", {error_reg, status_reg[0]}, {8'h04, 1'b1});
    check("status", status_reg, 8'h51);
    ack();
    $display("test power and abort done");
    native_disk_mode = 1;
    taskfile.drive_head_reg = 8'h10;
    for (int k = 1; k < 8; k++) begin
      diag_code = k > 5 ? 3'h1 : 3'(k);
      slave_diag_code = k > 5 ? 4'(k - 3) : 4'h1;
      issue(scd_pkg::CMD_DIAG);
      wait_for(0);
      check("diag", error_reg, k > 5 ? {4'h8, 4'(k - 3)} : 8'(k));
      ack();
    end
    slave_present = 0;
    diag_code = 3'h2;
    slave_diag_code = 4'h3;
    issue(scd_pkg::CMD_DIAG);
    wait_for(0);
    check("diag alone", error_reg, 8'h02);
    ack();
    slave_present = 1;
    native_disk_mode = 0;
    issue(scd_pkg::CMD_DIAG);
    repeat (3) @(negedge ref_clk);
    check("unselected", {status_reg[7], intr_req}, 2'h0);
    taskfile.drive_head_reg = 8'h00;
    issue(scd_pkg::CMD_DIAG);
    wait_for(0);
    check("diag card", error_reg, 8'h02);
    ack();
    $display("test diag done");
    taskfile = '{8'h00, 8'h02, 8'h56, 16'h1234, 8'hEA};
    erase_fault = 1;
    issue(scd_pkg::CMD_ERASE);
    wait_for(0);
    check("erase address", erase_addr, 28'hA123456);
    check("erase count", erase_count, 8'h02);
    check("wfault", status_reg[5], 1'b1);
    ack();
    erase_fault = 0;
    power_state = scd_pkg::PWR_IDLE;
    issue(scd_pkg::CMD_PWR_A);
    wait_for(0);
    check("count head", sector_count_out, 8'hFF);
    ack();
    taskfile.drive_head_reg = 8'h1A;
    issue(scd_pkg::CMD_PWR_A);
    repeat (3) @(negedge ref_clk);
    check("other drive", {status_reg[7], intr_req}, 2'h0);
    taskfile.drive_head_reg = 8'hEA;
    $display("test erase done");
    for (int m = 0; m < 2; m++) begin
      issue(m ? scd_pkg::CMD_WRM_NOERASE : scd_pkg::CMD_WR_NOERASE);
      wait_for(1);
      check("data request", {status_reg[7], write_no_erase, multi_sector}, {2'h1, m[0]});
      wait_for(0);
      ack();
    end
    $display("test writes done");
    conclude();
  end
endmodule // tb_scd_decoder
